/* fac_consts.svh */
`ifndef FAC_CONSTS_SVH
`define FAC_CONSTS_SVH
`define FAC_OFF_SYSCFG 8'h00
`define FAC_OFF_STATUS 8'h04
`define FAC_OFF_PROTECT 8'h08
`define FAC_OFF_CTRL 8'h0C
`define FAC_SYS_INTERNAL_ROM_ENABLE 0
`define FAC_SYS_ROM_SEGMENT_SELECT 1
`define FAC_CW_FWE 0
`define FAC_CW_FEE 1
`define FAC_CW_BUSY 2
`define FAC_CW_DOUBLE_WORD_WRITE_SELECT 7
`define FAC_CW_BE_LO 8
`define FAC_CW_FWMSET 15
`define FAC_CW_RESET 16'h0000
`define FAC_CW_WMASK 16'h8383
`define FAC_SEG_LOW0 9'h000
`define FAC_SEG_LOW1 9'h002
`define FAC_SEG_UP_FIRST 9'h003
`define FAC_SEG_UP_LAST 9'h005
`define FAC_UP_SHIFT 18'h10000
`define FAC_BLK1_START 15'h3000
`define FAC_BLK2_START 15'h6000
`define FAC_BLK3_START 15'h7800
`define FAC_ARRAY_LAST 15'h7FFF
`define FAC_ERASED_WORD 32'hFFFFFFFF
`define FAC_CLK_MHZ 50
`define FAC_PROG_TIME_US 100
`define FAC_ERASE_TIME_MS 1000
`define FAC_PROG_CYC (`FAC_PROG_TIME_US * `FAC_CLK_MHZ)
`define FAC_ERASE_CYC (`FAC_ERASE_TIME_MS * 1000 * `FAC_CLK_MHZ)
`endif

/* fac_pkg.sv */
package fac_pkg;
  typedef enum logic [1:0] {
    FAC_IDLE = 2'h0,
    FAC_PROG = 2'h1,
    FAC_ERASE = 2'h2
  } fac_state_e;
  typedef logic [14:0] fac_index_t;
endpackage : fac_pkg

/* fac_flash_ctrl.sv */
// How it works
// - Array words are 32 bits so a double-word fetch completes in one access.
// - Four erase banks of 48, 48, 24 and 8 KByte.
// - Erase writes all ones into every bit of the bank.
// - Program and erase are refused outside writing mode.
// - Program lasts about 100 us, bank erase about one second.
// - With protection on, array reads from code outside flash are blocked.
// - Lower 32 KByte sits in segment 0 or 1 by rom segment select.
// - Upper 96 KByte always decodes from 01'8000 upward.
// - External access select pin, sampled at reset, sets the boot source.
// - After external boot the flash stays hidden until internal rom enable is set.
// - Segment 0 mapping overrides external memory; segment 1 mapping leaves it visible.
// - System configuration writes are ignored after end of initialisation.
// - Control word is locked and ineffective in standard mode.
// - Even direct word writes, and in writing mode also reads, hit the control word; indirect ones hit the array.
// - Standard mode reads behave like on-chip ROM for fetches and operands.
// - Writing mode offers word, double-word programming, bank erase and verify reads.
// - Double word write select picks 16 or 32 bit programming.
//
// The APB slave port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "fac_consts.svh"
module fac_flash_ctrl #(
  parameter int PROG_CYC = `FAC_PROG_CYC,
  parameter int ERASE_CYC = `FAC_ERASE_CYC,
  parameter logic [15:0] KEY_FIRST = 16'hA5A5,
  parameter logic [15:0] KEY_SECOND = 16'h5A5A
) (
  input wire logic clk_sys, // System clock.
  input wire logic rst_n, // Synchronous reset, active low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire logic pwrite, // APB direction.
  input wire logic [7:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error.
  input wire logic ext_access_sel, // Boot source pin.
  input wire logic cpu_req, // Access request, one cycle.
  input wire logic [23:0] cpu_addr, // Byte address.
  input wire logic cpu_wr, // Write access.
  input wire logic cpu_direct, // Direct addressing.
  input wire logic cpu_byte, // Byte access.
  input wire logic [31:0] cpu_wdata, // Write data.
  input wire logic cpu_from_flash, // Issuing code lies in flash.
  input wire logic cpu_end_of_init, // End of init instruction pulse.
  output logic cpu_ack, // Access answered.
  output logic cpu_hit, // Access decoded to flash.
  output logic cpu_err, // Access refused.
  output logic [31:0] cpu_rdata, // Read data.
  output logic flash_busy, // Operation running.
  output logic writing_mode // Writing mode active.
);
  import fac_pkg::*;

  if (PROG_CYC < 16 || ERASE_CYC < 16 || ERASE_CYC > 32'h03FFFFFF || PROG_CYC > ERASE_CYC) begin : g_bad_cycles
    $error("fac_flash_ctrl: unusable cycle counts");
  end

  function automatic logic [15:0] fac_decode(input logic [23:0] a, input logic en, input logic seg1);
    logic [8:0] seg;
    logic lo;
    logic up;
    logic [17:0] off;
    seg = a[23:15];
    lo = en & (seg1 ? (seg == `FAC_SEG_LOW1) : (seg == `FAC_SEG_LOW0));
    up = en & (seg >= `FAC_SEG_UP_FIRST) & (seg <= `FAC_SEG_UP_LAST);
    off = lo ? {3'h0, a[14:0]} : (a[17:0] - `FAC_UP_SHIFT);
    return {lo | up, off[16:2]};
  endfunction : fac_decode

  function automatic fac_index_t fac_bank_start(input logic [1:0] b);
    case (b)
      2'h0: return 15'h0000;
      2'h1: return `FAC_BLK1_START;
      2'h2: return `FAC_BLK2_START;
      default: return `FAC_BLK3_START;
    endcase
  endfunction : fac_bank_start

  function automatic fac_index_t fac_bank_last(input logic [1:0] b);
    fac_index_t e;
    e = (b == 2'h3) ? `FAC_ARRAY_LAST : fac_bank_start(b + 2'h1) - 15'h0001;
    return e;
  endfunction : fac_bank_last

  // Four banks of 48/48/24/8 KByte within 32768 words of 32 bits.
  logic [31:0] mem [0:32767];

  logic ea_s1_q, ea_s2_q;
  logic internal_rom_enable_q, rom_segment_select_q, eoi_q, prot_q;
  logic wmode_q, key_stage_q;
  logic [15:0] cw_q;
  fac_state_e st_q, st_d;
  logic [25:0] tmr_q;
  fac_index_t ptr_q, last_q, idx_q;
  logic pready_q, pslverr_q, ack_q, hit_q, err_q, busy_q;
  logic [31:0] prdata_q, rdata_q;

  wire logic [15:0] dec = fac_decode(cpu_addr, internal_rom_enable_q, rom_segment_select_q);
  wire logic hit = cpu_req & dec[15];
  wire fac_index_t idx = dec[14:0];
  wire logic busy = (st_q != FAC_IDLE);
  wire logic cw_form = cpu_direct & ~cpu_byte & ~cpu_addr[0];
  wire logic cw_sel = hit & cw_form & (wmode_q | cpu_wr);
  wire logic dir_bad = hit & cpu_direct & ~cw_form & wmode_q;
  wire logic key1 = cw_sel & cpu_wr & ~wmode_q & ~key_stage_q & (cpu_wdata[15:0] == KEY_FIRST);
  wire logic key2 = cw_sel & cpu_wr & ~wmode_q & key_stage_q & (cpu_wdata[15:0] == KEY_SECOND);
  wire logic cw_wr = cw_sel & cpu_wr & wmode_q & ~busy;
  wire logic arr_wr = hit & cpu_wr & ~cpu_direct;
  wire logic op_ok = arr_wr & wmode_q & cw_q[`FAC_CW_FWE] & ~busy;
  wire logic start_prog = op_ok & ~cw_q[`FAC_CW_FEE];
  wire logic start_erase = op_ok & cw_q[`FAC_CW_FEE];
  wire logic rd_blocked = prot_q & ~cpu_from_flash;
  wire logic arr_rd = hit & ~cpu_wr & ~cw_sel & ~dir_bad;
  wire logic [15:0] cw_view = {wmode_q, cw_q[14:3], busy, cw_q[1:0]};
  wire logic [31:0] half_lo = {16'hFFFF, cpu_wdata[15:0]};
  wire logic [31:0] half_hi = {cpu_wdata[15:0], 16'hFFFF};
  wire logic [31:0] pattern = cw_q[`FAC_CW_DOUBLE_WORD_WRITE_SELECT] ? cpu_wdata : (cpu_addr[1] ? half_hi : half_lo);
  // Programming can only clear bits, so the new word is the old one ANDed with the pattern.
  wire logic mem_we = start_prog | (st_q == FAC_ERASE);
  wire fac_index_t mem_idx = start_prog ? idx : ptr_q;
  wire logic [31:0] mem_wdat = start_prog ? (mem[idx] & pattern) : `FAC_ERASED_WORD;
  wire logic apb_acc = psel & penable & ~pready_q;
  wire logic apb_fire = psel & penable & pready_q & pwrite;
  wire logic off_sys = (paddr == `FAC_OFF_SYSCFG);
  wire logic off_stat = (paddr == `FAC_OFF_STATUS);
  wire logic off_prot = (paddr == `FAC_OFF_PROTECT);
  wire logic off_ctrl = (paddr == `FAC_OFF_CTRL);
  wire logic [31:0] stat_word = {26'h0, ea_s2_q, prot_q, eoi_q, busy, key_stage_q, wmode_q};
  wire logic [31:0] apb_rd = off_sys ? {30'h0, rom_segment_select_q, internal_rom_enable_q} :
                             off_stat ? stat_word :
                             off_prot ? {31'h0, prot_q} :
                             off_ctrl ? {16'h0, cw_view} : 32'h00000000;
  wire logic rd_ok = arr_rd & ~busy & ~rd_blocked;
  wire logic [31:0] rd_val = cw_sel ? {16'h0, cw_view} : (rd_ok ? mem[idx] : 32'h00000000);
  wire logic acc_err = dir_bad | (arr_wr & ~op_ok) | (arr_rd & ~rd_ok) | (cw_sel & cpu_wr & wmode_q & busy);

  always_ff @(posedge clk_sys) begin
    ea_s1_q <= ext_access_sel;
    ea_s2_q <= ea_s1_q;
  end

  always_ff @(posedge clk_sys) begin
    if (mem_we) begin
      mem[mem_idx] <= mem_wdat;
    end
  end

  // Reset is synchronous, so the synchronised boot pin is taken as the enable's reset value.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      internal_rom_enable_q <= ea_s2_q;
      rom_segment_select_q <= 1'b0;
      eoi_q <= 1'b0;
      prot_q <= 1'b0;
    end else begin
      eoi_q <= eoi_q | cpu_end_of_init;
      if (apb_fire && off_sys && !eoi_q) begin
        internal_rom_enable_q <= pwdata[`FAC_SYS_INTERNAL_ROM_ENABLE];
        rom_segment_select_q <= pwdata[`FAC_SYS_ROM_SEGMENT_SELECT];
      end
      if (apb_fire && off_prot && pwdata[0]) begin
        prot_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wmode_q <= 1'b0;
      key_stage_q <= 1'b0;
      cw_q <= `FAC_CW_RESET;
    end else begin
      if (cpu_req) begin
        key_stage_q <= key1;
      end
      if (key2) begin
        wmode_q <= 1'b1;
      end else if (cw_wr) begin
        wmode_q <= cpu_wdata[`FAC_CW_FWMSET];
        cw_q <= cpu_wdata[`FAC_CW_FWMSET] ? (cpu_wdata[15:0] & `FAC_CW_WMASK) : `FAC_CW_RESET;
      end
    end
  end

  always_comb begin
    st_d = st_q;
    case (st_q)
      FAC_IDLE: begin
        if (start_prog) begin
          st_d = FAC_PROG;
        end else if (start_erase) begin
          st_d = FAC_ERASE;
        end
      end
      FAC_PROG: begin
        if (tmr_q == 26'h0) begin
          st_d = FAC_IDLE;
        end
      end
      FAC_ERASE: begin
        if (tmr_q == 26'h0 && ptr_q == last_q) begin
          st_d = FAC_IDLE;
        end
      end
      default: st_d = FAC_IDLE;
    endcase
  end

  // The erase walks one word per cycle, hidden inside the much longer erase time.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_q <= FAC_IDLE;
      busy_q <= 1'b0;
      tmr_q <= 26'h0;
      ptr_q <= 15'h0000;
      last_q <= 15'h0000;
    end else begin
      st_q <= st_d;
      busy_q <= (st_d != FAC_IDLE);
      if (start_prog) begin
        tmr_q <= 26'(PROG_CYC - 1);
      end else if (start_erase) begin
        tmr_q <= 26'(ERASE_CYC - 1);
        ptr_q <= fac_bank_start(cw_q[`FAC_CW_BE_LO +: 2]);
        last_q <= fac_bank_last(cw_q[`FAC_CW_BE_LO +: 2]);
      end else if (busy) begin
        if (tmr_q != 26'h0) begin
          tmr_q <= tmr_q - 26'h1;
        end
        if (st_q == FAC_ERASE && ptr_q != last_q) begin
          ptr_q <= ptr_q + 15'h0001;
        end
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
      hit_q <= 1'b0;
      err_q <= 1'b0;
      rdata_q <= 32'h00000000;
      idx_q <= 15'h0000;
    end else begin
      ack_q <= hit;
      hit_q <= hit;
      err_q <= hit & acc_err;
      rdata_q <= (hit && !cpu_wr) ? rd_val : 32'h00000000;
      idx_q <= idx;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else begin
      pready_q <= apb_acc;
      pslverr_q <= apb_acc & ~(off_sys | off_stat | off_prot | off_ctrl);
      prdata_q <= (apb_acc && !pwrite) ? apb_rd : 32'h00000000;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign cpu_ack = ack_q;
  assign cpu_hit = hit_q;
  assign cpu_err = err_q;
  assign cpu_rdata = rdata_q;
  assign flash_busy = busy_q;
  assign writing_mode = wmode_q;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  wire logic [8:0] seg_in = cpu_addr[23:15];

  property p_refuse_locked;
    arr_wr && !wmode_q |=> cpu_err && !flash_busy;
  endproperty
  a_refuse_locked: assert property (p_refuse_locked) else $error("program accepted outside writing mode");

  property p_prog_time;
    start_prog |=> flash_busy [*8];
  endproperty
  a_prog_time: assert property (p_prog_time) else $error("program ended too early");

  property p_protect;
    hit && !cpu_wr && !cw_sel && rd_blocked |=> cpu_err && cpu_rdata == 32'h00000000;
  endproperty
  a_protect: assert property (p_protect) else $error("protected read leaked data");

  property p_seg0;
    cpu_req && internal_rom_enable_q && !rom_segment_select_q && seg_in == 9'h000 |=> cpu_hit;
  endproperty
  a_seg0: assert property (p_seg0) else $error("segment 0 mapping missed");

  property p_upper;
    cpu_req && internal_rom_enable_q && seg_in >= 9'h003 && seg_in <= 9'h005 |=> cpu_hit && cpu_ack ##1 (!cpu_ack || $past(cpu_req));
  endproperty
  a_upper: assert property (p_upper) else $error("upper flash not decoded");

  property p_hidden;
    cpu_req && !internal_rom_enable_q |=> !cpu_hit && !cpu_ack;
  endproperty
  a_hidden: assert property (p_hidden) else $error("flash visible while disabled");

  property p_seg1_ext;
    cpu_req && rom_segment_select_q && seg_in == 9'h000 |=> !cpu_hit;
  endproperty
  a_seg1_ext: assert property (p_seg1_ext) else $error("segment 0 overridden in segment 1 mapping");

  property p_cfg_frozen;
    eoi_q |=> $stable(internal_rom_enable_q) && $stable(rom_segment_select_q);
  endproperty
  a_cfg_frozen: assert property (p_cfg_frozen) else $error("configuration changed after init");

  property p_cw_locked;
    !wmode_q && !key2 |=> $stable(cw_q);
  endproperty
  a_cw_locked: assert property (p_cw_locked) else $error("control word changed while locked");

  property p_abort;
    key_stage_q && cpu_req && !key2 |=> !wmode_q;
  endproperty
  a_abort: assert property (p_abort) else $error("broken unlock entered writing mode");
endmodule : fac_flash_ctrl
`default_nettype wire

/* fac_cpu_model.sv */
`timescale 1ns/10ps
`default_nettype none
module fac_cpu_model (
  input wire logic clk_sys, // Clock.
  output logic cpu_req, // Request pulse.
  output logic [23:0] cpu_addr, // Byte address.
  output logic cpu_wr, // Write.
  output logic cpu_direct, // Direct addressing.
  output logic cpu_byte, // Byte access.
  output logic [31:0] cpu_wdata, // Write data.
  output logic cpu_from_flash, // Issuing code lies in flash.
  input wire logic cpu_ack, // Answer.
  input wire logic cpu_hit, // Decoded to flash.
  input wire logic cpu_err, // Refused.
  input wire logic [31:0] cpu_rdata // Read data.
);
  initial begin
    {cpu_req, cpu_wr, cpu_direct, cpu_byte, cpu_from_flash} = 5'h00;
    cpu_addr = 24'h000000;
    cpu_wdata = 32'h00000000;
  end
  // Address and data are inverted once released, so a design that keeps using them shows it.
  task automatic access(input logic [3:0] m, input logic [23:0] a, input logic [31:0] d,
                        output logic [2:0] ahe, output logic [31:0] rd);
    @(posedge clk_sys);
    cpu_req <= 1'b1;
    {cpu_wr, cpu_direct, cpu_byte, cpu_from_flash} <= m;
    cpu_addr <= a;
    cpu_wdata <= d;
    @(posedge clk_sys);
    cpu_req <= 1'b0;
    cpu_addr <= ~a;
    cpu_wdata <= ~d;
    @(negedge clk_sys);
    ahe = {cpu_ack, cpu_hit, cpu_err};
    rd = cpu_rdata;
  endtask : access
endmodule : fac_cpu_model
`default_nettype wire

/* flash_memory_access_control_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module flash_memory_access_control_bench;
  import fac_pkg::*;
  localparam int PC = 20;
  localparam int EC = 12300;
  localparam logic [15:0] KF = 16'hA5A5;
  localparam logic [15:0] KS = 16'h5A5A;
  // Mode codes are {write, direct, byte, from_flash}; all writes run from RAM.
  localparam logic [3:0] RDF = 4'h1;
  localparam logic [3:0] RDR = 4'h0;
  localparam logic [3:0] WRI = 4'h8;
  localparam logic [3:0] WRD = 4'hC;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata, cpu_wdata, cpu_rdata, rd, r;
  logic pready, pslverr, cpu_req, cpu_wr, cpu_direct, cpu_byte, cpu_from_flash;
  logic cpu_ack, cpu_hit, cpu_err, flash_busy, writing_mode;
  logic ext_access_sel = 1'b0;
  logic cpu_end_of_init = 1'b0;
  logic [23:0] cpu_addr;
  logic [2:0] ahe;
  logic [32:0] ar;
  logic [31:0] xs = 32'h0000993D;
  logic [31:0] mem [int];
  int err_total = 0, n_tests = 0, cyc = 0;

  fac_flash_ctrl #(.PROG_CYC(PC), .ERASE_CYC(EC), .KEY_FIRST(KF), .KEY_SECOND(KS)) fac_flash_ctrl_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_access_sel(ext_access_sel),
    .cpu_req(cpu_req), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr), .cpu_direct(cpu_direct), .cpu_byte(cpu_byte),
    .cpu_wdata(cpu_wdata), .cpu_from_flash(cpu_from_flash), .cpu_end_of_init(cpu_end_of_init),
    .cpu_ack(cpu_ack), .cpu_hit(cpu_hit), .cpu_err(cpu_err), .cpu_rdata(cpu_rdata),
    .flash_busy(flash_busy), .writing_mode(writing_mode));
  fac_cpu_model fac_cpu_model_inst (
    .clk_sys(clk_sys), .cpu_req(cpu_req), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr), .cpu_direct(cpu_direct),
    .cpu_byte(cpu_byte), .cpu_wdata(cpu_wdata), .cpu_from_flash(cpu_from_flash), .cpu_ack(cpu_ack),
    .cpu_hit(cpu_hit), .cpu_err(cpu_err), .cpu_rdata(cpu_rdata));

  always #10 clk_sys = ~clk_sys;

  function automatic logic [31:0] rnd();
    xs ^= xs << 13;
    xs ^= xs >> 17;
    xs ^= xs << 5;
    return xs;
  endfunction : rnd

  task automatic tally_and_finish();
    if (err_total == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // A timeout is better than a hang when the design never answers.
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 40000) begin
      err_total++;
      tally_and_finish();
    end
  end

  task automatic do_reset(input logic pin);
    rst_n <= 1'b0;
    ext_access_sel <= pin;
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
  endtask : do_reset

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk_sys);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (pready !== 1'b1) begin
      err_total++;
      tally_and_finish();
    end
    // Taken at the very edge that samples pready high; the write lands at this edge too.
    ar = {pslverr, prdata};
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;
  endtask : apb

  task automatic go(input logic [3:0] m, input logic [23:0] a, input logic [31:0] d);
    fac_cpu_model_inst.access(m, a, d, ahe, rd);
  endtask : go

  task automatic cpu(input logic [3:0] m, input logic [23:0] a, input logic [31:0] d, input logic [2:0] e);
    go(m, a, d);
    chk({30'h0, ahe}, {30'h0, e});
  endtask : cpu

  task automatic run(input int n);
    int c;
    c = 0;
    while (flash_busy === 1'b1 && c < n + 9) begin
      @(negedge clk_sys);
      c++;
    end
    chk(33'(c), 33'(n));
  endtask : run

  task automatic pgm(input logic dw, input logic [23:0] a, input logic [31:0] d);
    int k;
    k = int'(a >> 2);
    go(WRD, 24'h018000, dw ? 32'h00008081 : 32'h00008001);
    cpu(WRI, a, d, 3'b110);
    run(PC);
    if (!mem.exists(k))
      mem[k] = 32'hFFFFFFFF;
    mem[k] &= dw ? d : (a[1] ? {d[15:0], 16'hFFFF} : {16'hFFFF, d[15:0]});
    cpu(RDF, {a[23:2], 2'b00}, 32'h0, 3'b110);
    chk({1'b0, rd}, {1'b0, mem[k]});
  endtask : pgm

  initial begin
    do_reset(1'b0);
    @(negedge clk_sys);
    chk({31'h0, writing_mode, flash_busy}, 33'h0);
    apb(1'b0, 8'h00, 32'h0);
    chk(ar, 33'h0);
    cpu(RDF, 24'h018000, 32'h0, 3'b000);
    apb(1'b1, 8'h00, 32'h00000003);
    apb(1'b0, 8'h00, 32'h0);
    chk(ar, 33'h3);
    // The inter-segment branch after remapping fetches from the upper flash first.
    cpu(RDF, 24'h018000, 32'h0, 3'b110);
    cpu(RDF, 24'h000000, 32'h0, 3'b000);
    cpu(RDF, 24'h010000, 32'h0, 3'b110);
    cpu(RDF, 24'h018000, 32'h0, 3'b110);
    @(posedge clk_sys);
    cpu_end_of_init <= 1'b1;
    @(posedge clk_sys);
    cpu_end_of_init <= 1'b0;
    apb(1'b1, 8'h00, 32'h00000001);
    apb(1'b0, 8'h00, 32'h0);
    chk(ar, 33'h3);
    apb(1'b0, 8'h10, 32'h0);
    chk({32'h0, ar[32]}, 33'h1);
    do_reset(1'b1);
    apb(1'b0, 8'h00, 32'h0);
    chk(ar, 33'h1);
    cpu(RDF, 24'h000000, 32'h0, 3'b110);
    cpu(WRI, 24'h02E000, 32'h0, 3'b111);
    go(WRD, 24'h018000, 32'h00008303);
    apb(1'b0, 8'h0C, 32'h0);
    chk(ar, 33'h0);
    go(WRD, 24'h018000, {16'h0, KF});
    go(RDF, 24'h018000, 32'h0);
    go(WRD, 24'h018000, {16'h0, KS});
    chk({32'h0, writing_mode}, 33'h0);
    go(WRD, 24'h018000, {16'h0, KF});
    go(WRD, 24'h018000, {16'h0, KS});
    chk({32'h0, writing_mode}, 33'h1);
    go(WRD, 24'h018000, 32'h00008303);
    apb(1'b0, 8'h0C, 32'h0);
    chk(ar, 33'h8303);
    cpu(WRI, 24'h02E000, 32'h0, 3'b110);
    run(EC);
    cpu(RDF, 24'h02E000, 32'h0, 3'b110);
    chk({1'b0, rd}, 33'hFFFFFFFF);
    cpu(RDF, 24'h02FFFC, 32'h0, 3'b110);
    chk({1'b0, rd}, 33'hFFFFFFFF);
    pgm(1'b1, 24'h02E000, rnd());
    r = rnd();
    pgm(1'b0, 24'h02E006, r);
    pgm(1'b0, 24'h02E008, r);
    cpu(4'hE, 24'h018000, 32'h0, 3'b111);
    apb(1'b1, 8'h08, 32'h00000001);
    cpu(RDR, 24'h02E000, 32'h0, 3'b111);
    chk({1'b0, rd}, 33'h0);
    cpu(RDF, 24'h02E004, 32'h0, 3'b110);
    chk({1'b0, rd}, {1'b0, mem[int'(24'h02E004 >> 2)]});
    tally_and_finish();
  end
endmodule : flash_memory_access_control_bench
`default_nettype wire
